// *** src/aic_interrupt_ctrl.sv ***
// Interrupt controller core: eight engines, hold modes, pin routing, APB registers
//
// Notes on behaviour
// (RULE_01) Eight engines, enabled ones set flag and pin
// (RULE_02) Each pin is OR of routed sources
// (RULE_03) Flags update only on new sample write
// (RULE_04) Disabling an engine clears its flags immediately
// (RULE_05) Shared mode field: non-latched, latched or timed
// (RULE_06) Timed mode clears after coded hold period
// (RULE_07) Active condition blocks clearing
// (RULE_08) Non-latched clears when condition ends; some auto-clear
// (RULE_09) Latch-clear bit 7 clears; reassert on update
// (RULE_10) Source select picks filtered or unfiltered input
// (RULE_11) Host disables, reconfigures, waits 10 ms, re-enables
// (RULE_12) Routing registers connect sources to pins
// (RULE_13) Polarity bits 0 and 2 set active level
// (RULE_14) Bits 1 and 3 select open-drain driver
// (RULE_15) New-sample flag clears at acquisition, 50 us gap
// (RULE_16) New-sample always non-latched, enable and status bits
// (RULE_17) First new-sample after wake may come late
// (RULE_18) Slope is absolute difference versus threshold
// (RULE_19) Slope changes after N consecutive points
// (RULE_20) Any axis asserts; all axes below clear
// (RULE_21) Eight-bit unsigned slope threshold
// (RULE_22) Hold counted per engine from flag assertion
// (RULE_23) Reset clears flags, pins inactive
`timescale 1ns/1ps
`default_nettype none

module aic_interrupt_ctrl #(
   parameter int unsigned HOLD_UNIT_CYC = aic_pkg::HOLD_UNIT_CYC_DEF,
   parameter int unsigned ND_GAP_CYC = aic_pkg::ND_GAP_CYC_DEF,
   parameter int unsigned AUTO_CLR_CYC = aic_pkg::AUTO_CLR_CYC_DEF
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire aic_pkg::aic_apb_req_t apb_req,
   output aic_pkg::aic_apb_rsp_t apb_rsp,
   input wire aic_pkg::aic_sample_t samp_filt,
   input wire aic_pkg::aic_sample_t samp_unf,
   input wire logic acc_wr,
   input wire logic acq_start,
   input wire logic [7:0] ext_cond_filt,
   input wire logic [7:0] ext_cond_unf,
   output aic_pkg::aic_pin_t irq_pin_a,
   output aic_pkg::aic_pin_t irq_pin_b
);
   import aic_pkg::*;

   typedef struct packed {
      logic [7:0] en_a;
      logic [7:0] en_b;
      logic [7:0] route_a;
      logic [7:0] route_b;
      logic [7:0] src;
      logic [7:0] outctl;
      logic [3:0] hold;
      logic [1:0] slope_dur;
      logic [7:0] thresh;
      logic [7:0] flags;
      logic [7:0][31:0] hold_cnt;
      logic [31:0] nd_gap;
      logic prev_ok;
      logic signed [13:0] prev_x;
      logic signed [13:0] prev_y;
      logic signed [13:0] prev_z;
      logic slope_cond;
      logic [2:0] above_cnt;
      logic [2:0] below_cnt;
      aic_pin_t pin_a;
      aic_pin_t pin_b;
      logic [31:0] prdata;
   } aic_state_t;

   aic_state_t st_r;
   aic_state_t st_nxt;

   logic [7:0] idx;
   logic [7:0] rd8;
   logic [7:0] cond;
   logic [7:0] en_vec;
   logic [7:0] act_a_v;
   logic [7:0] act_b_v;
   logic hit;
   logic wr;
   logic latch_clr;
   logic upd;
   logic any_above;
   logic [2:0] need_n;
   logic [31:0] lim;
   aic_mode_t mode;
   aic_sample_t sl;

   // Absolute difference of two signed samples, one bit wider
   function automatic logic [14:0] absdiff(input logic signed [13:0] a,
                                           input logic signed [13:0] b);
      logic signed [14:0] d;
      d = {a[13], a} - {b[13], b};
      return d[14] ? 15'(-d) : d;
   endfunction : absdiff

   // Map of the sixteen mode codes onto the three behaviours
   function automatic aic_mode_t decode_mode(input logic [3:0] code);
      if (code == MODE_NL0 || code == MODE_NL1) begin
         return MD_NONLATCH;
      end else if (code == MODE_LAT0 || code == MODE_LAT1) begin
         return MD_LATCH;
      end else begin
         return MD_TIMED;
      end
   endfunction : decode_mode

   // Address decode; misaligned or out-of-window addresses miss
   function automatic logic reg_hit(input logic [11:0] a);
      logic [7:0] i;
      i = a[9:2];
      return (a[1:0] == 2'b00) && (a[11:10] == 2'b00) &&
         (i == REG_FLAGS_A_IDX || i == REG_FLAGS_B_IDX ||
          i == REG_EN_A_IDX || i == REG_EN_B_IDX ||
          i == REG_ROUTE_A_IDX || i == REG_ROUTE_B_IDX ||
          i == REG_SRC_IDX || i == REG_OUTCTL_IDX || i == REG_HOLD_IDX ||
          i == REG_SLOPE_DUR_IDX || i == REG_THRESH_IDX);
   endfunction : reg_hit

   // Zero-wait slave; a frozen core stretches the access phase
   assign apb_rsp.prdata = st_r.prdata;
   assign apb_rsp.pready = ce;
   assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~hit;
   assign irq_pin_a = st_r.pin_a;
   assign irq_pin_b = st_r.pin_b;

   // Next-state logic for registers, engines and pins
   always_comb begin
      st_nxt = st_r;
      idx = apb_req.paddr[9:2];
      hit = reg_hit(apb_req.paddr);
      wr = apb_req.psel & apb_req.penable & apb_req.pwrite & hit;
      latch_clr = wr && (idx == REG_HOLD_IDX) &&
         apb_req.pwdata[LATCH_CLR_BIT];
      upd = acc_wr;
      mode = decode_mode(st_r.hold);
      lim = HOLD_UNIT_CYC * 32'(hold_units(st_r.hold));
      need_n = {1'b0, st_r.slope_dur} + 3'h1;
      any_above = 1'b0;
      rd8 = 8'h00;

      // Read data is captured in the setup phase
      unique case (idx)
         REG_FLAGS_A_IDX: rd8 = {st_r.flags[7:1], 1'b0};
         REG_FLAGS_B_IDX: rd8 = {st_r.flags[E_DATA], 7'h00}; // RULE_16
         REG_EN_A_IDX: rd8 = st_r.en_a;
         REG_EN_B_IDX: rd8 = st_r.en_b;
         REG_ROUTE_A_IDX: rd8 = st_r.route_a;
         REG_ROUTE_B_IDX: rd8 = st_r.route_b;
         REG_SRC_IDX: rd8 = {2'b00, st_r.src[5:0]};
         REG_OUTCTL_IDX: rd8 = {4'h0, st_r.outctl[3:0]};
         REG_HOLD_IDX: rd8 = {4'h0, st_r.hold};
         REG_SLOPE_DUR_IDX: rd8 = {6'h00, st_r.slope_dur};
         REG_THRESH_IDX: rd8 = st_r.thresh;
         default: rd8 = 8'h00;
      endcase
      if (apb_req.psel && !apb_req.penable) begin
         st_nxt.prdata = {24'h000000, rd8};
      end

      // Register writes take effect in the access phase
      if (wr) begin
         unique case (idx)
            REG_EN_A_IDX: st_nxt.en_a = apb_req.pwdata[7:0];
            REG_EN_B_IDX: st_nxt.en_b = apb_req.pwdata[7:0];
            REG_ROUTE_A_IDX: st_nxt.route_a = apb_req.pwdata[7:0];
            REG_ROUTE_B_IDX: st_nxt.route_b = apb_req.pwdata[7:0];
            REG_SRC_IDX: st_nxt.src = {2'b00, apb_req.pwdata[5:0]};
            REG_OUTCTL_IDX: st_nxt.outctl = {4'h0, apb_req.pwdata[3:0]};
            REG_HOLD_IDX: st_nxt.hold = apb_req.pwdata[3:0]; // RULE_05
            REG_SLOPE_DUR_IDX: st_nxt.slope_dur = apb_req.pwdata[1:0];
            REG_THRESH_IDX: st_nxt.thresh = apb_req.pwdata[7:0]; // RULE_21
            default: st_nxt.flags = st_nxt.flags;
         endcase
      end

      // Slope engine runs on the chosen data stream
      sl = st_r.src[SRC_SLOPE_BIT] ? samp_unf : samp_filt; // RULE_10
      if (sl.valid) begin
         st_nxt.prev_x = sl.x;
         st_nxt.prev_y = sl.y;
         st_nxt.prev_z = sl.z;
         st_nxt.prev_ok = 1'b1;
         any_above = // RULE_18 RULE_21
            (st_r.en_a[0] && absdiff(sl.x, st_r.prev_x) >
             {3'b000, st_r.thresh, 4'h0}) ||
            (st_r.en_a[1] && absdiff(sl.y, st_r.prev_y) >
             {3'b000, st_r.thresh, 4'h0}) ||
            (st_r.en_a[2] && absdiff(sl.z, st_r.prev_z) >
             {3'b000, st_r.thresh, 4'h0}); // RULE_20
         if (st_r.prev_ok && any_above) begin
            st_nxt.below_cnt = 3'h0;
            if (st_r.above_cnt < need_n) begin
               st_nxt.above_cnt = st_r.above_cnt + 3'h1;
            end
            if (st_r.above_cnt + 3'h1 >= need_n) begin
               st_nxt.slope_cond = 1'b1; // RULE_19
            end
         end else if (st_r.prev_ok) begin
            st_nxt.above_cnt = 3'h0;
            if (st_r.below_cnt < need_n) begin
               st_nxt.below_cnt = st_r.below_cnt + 3'h1;
            end
            if (st_r.below_cnt + 3'h1 >= need_n) begin
               st_nxt.slope_cond = 1'b0; // RULE_19 RULE_20
            end
         end
      end

      // Enables come from the freshly written values, so a disable acts now
      en_vec[E_DATA] = st_nxt.en_b[ND_EN_BIT]; // RULE_16
      en_vec[E_LOW] = st_nxt.en_a[EN_A_LOW_BIT];
      en_vec[E_HIGH] = st_nxt.en_a[EN_A_HIGH_BIT];
      en_vec[E_SLOPE] = |st_nxt.en_a[2:0];
      en_vec[E_NOMOT] = st_nxt.en_b[NOMOT_EN_BIT];
      en_vec[E_TAP] = st_nxt.en_a[EN_A_TAP_BIT];
      en_vec[E_ORIENT] = st_nxt.en_a[EN_A_ORIENT_BIT];
      en_vec[E_FLAT] = st_nxt.en_a[EN_A_FLAT_BIT];

      // Conditions; orientation and level pose always see filtered data
      cond[E_DATA] = 1'b0;
      cond[E_LOW] = st_r.src[SRC_LOW_BIT] ? ext_cond_unf[E_LOW] :
         ext_cond_filt[E_LOW]; // RULE_10
      cond[E_HIGH] = st_r.src[SRC_HIGH_BIT] ? ext_cond_unf[E_HIGH] :
         ext_cond_filt[E_HIGH];
      cond[E_SLOPE] = st_r.slope_cond;
      cond[E_NOMOT] = st_r.src[SRC_NOMOT_BIT] ? ext_cond_unf[E_NOMOT] :
         ext_cond_filt[E_NOMOT];
      cond[E_TAP] = st_r.src[SRC_TAP_BIT] ? ext_cond_unf[E_TAP] :
         ext_cond_filt[E_TAP];
      cond[E_ORIENT] = ext_cond_filt[E_ORIENT];
      cond[E_FLAT] = ext_cond_filt[E_FLAT];

      // Motion engines: set on sample write, clear by mode
      for (int e = 1; e < ENG_N; e++) begin
         if (st_r.flags[e] && st_r.hold_cnt[e] != 32'hFFFF_FFFF) begin
            st_nxt.hold_cnt[e] = st_r.hold_cnt[e] + 32'h1; // RULE_22
         end
         if (st_r.flags[e]) begin
            unique case (mode)
               MD_NONLATCH: begin
                  if (e == E_ORIENT || e == E_FLAT) begin
                     if (!cond[e] && st_r.hold_cnt[e] >= AUTO_CLR_CYC) begin
                        st_nxt.flags[e] = 1'b0; // RULE_08 RULE_07
                     end
                  end else if (upd && !cond[e]) begin
                     st_nxt.flags[e] = 1'b0; // RULE_08 RULE_03
                  end
               end
               MD_TIMED: begin
                  if (!cond[e] && st_r.hold_cnt[e] >= lim) begin
                     st_nxt.flags[e] = 1'b0; // RULE_06 RULE_07
                  end
               end
               MD_LATCH: begin
                  if (latch_clr) begin
                     st_nxt.flags[e] = 1'b0; // RULE_09
                  end
               end
            endcase
         end
         // A set in the clear cycle wins
         if (upd && cond[e]) begin
            if (!st_nxt.flags[e]) begin
               st_nxt.hold_cnt[e] = 32'h0; // RULE_22
            end
            st_nxt.flags[e] = 1'b1; // RULE_01 RULE_03 RULE_09
         end
      end

      // New-sample engine ignores the mode; gap counter keeps it low
      if (st_r.nd_gap != 32'h0) begin
         st_nxt.nd_gap = st_r.nd_gap - 32'h1;
      end
      if (acq_start && st_r.flags[E_DATA]) begin
         st_nxt.flags[E_DATA] = 1'b0; // RULE_15 RULE_16
         st_nxt.nd_gap = ND_GAP_CYC;
      end
      // Late first sample after wake only delays acc_wr upstream
      if (upd && st_r.nd_gap == 32'h0) begin
         st_nxt.flags[E_DATA] = 1'b1; // RULE_15 RULE_17
      end

      st_nxt.flags = st_nxt.flags & en_vec; // RULE_04

      // Pins follow the next flags so they never lag the status
      act_a_v = st_nxt.flags & st_nxt.route_a; // RULE_12
      act_b_v = st_nxt.flags & st_nxt.route_b; // RULE_12
      st_nxt.pin_a.o = st_nxt.outctl[POL_A_BIT] ? (|act_a_v) :
         !(|act_a_v); // RULE_02 RULE_13
      st_nxt.pin_b.o = st_nxt.outctl[POL_B_BIT] ? (|act_b_v) :
         !(|act_b_v); // RULE_02 RULE_13
      // Open drain only drives the active level; the pull sets the rest
      st_nxt.pin_a.oe = !st_nxt.outctl[OD_A_BIT] || (|act_a_v); // RULE_14
      st_nxt.pin_b.oe = !st_nxt.outctl[OD_B_BIT] || (|act_b_v); // RULE_14
   end

   // State register; polarity resets to active low so pins idle high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.en_a <= REG_RST;
         st_r.pin_a <= '{o: 1'b1, oe: 1'b1}; // RULE_23
         st_r.pin_b <= '{o: 1'b1, oe: 1'b1}; // RULE_23
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   property p_disable_clears;
      ce |=> ((st_r.flags & ~$past(en_vec)) == 8'h00);
   endproperty
   a_disable_clears: assert property (p_disable_clears) // RULE_04
      else $error("flag kept after its engine was disabled");

   property p_set_on_update;
      ((st_r.flags & ~$past(st_r.flags)) != 8'h00) |-> $past(acc_wr && ce);
   endproperty
   a_set_on_update: assert property (p_set_on_update) // RULE_03
      else $error("flag rose without a sample write");

   property p_pin_a_or;
      st_r.pin_a.o == (st_r.outctl[POL_A_BIT] ~^
         (|(st_r.flags & st_r.route_a)));
   endproperty
   a_pin_a_or: assert property (p_pin_a_or) // RULE_02
      else $error("pin one level does not match routed flags");

   property p_pin_b_pol;
      (st_r.outctl[POL_B_BIT] && (st_r.flags & st_r.route_b) == 8'h00) |->
         !st_r.pin_b.o;
   endproperty
   a_pin_b_pol: assert property (p_pin_b_pol) // RULE_13
      else $error("active-high pin two not low while idle");

   property p_open_drain;
      (st_r.outctl[OD_A_BIT] && (st_r.flags & st_r.route_a) == 8'h00) |->
         !st_r.pin_a.oe;
   endproperty
   a_open_drain: assert property (p_open_drain) // RULE_14
      else $error("open-drain pin one drives while inactive");

   property p_latched_holds;
      (ce && mode == MD_LATCH && st_r.flags[E_LOW] && !latch_clr &&
       en_vec[E_LOW]) |=> st_r.flags[E_LOW];
   endproperty
   a_latched_holds: assert property (p_latched_holds) // RULE_05
      else $error("latched low-g flag dropped without clear");

   property p_timed_expire;
      (ce && mode == MD_TIMED && st_r.flags[E_LOW] && !cond[E_LOW] &&
       !(acc_wr && cond[E_LOW]) && st_r.hold_cnt[E_LOW] >= lim) |=>
         !st_r.flags[E_LOW];
   endproperty
   a_timed_expire: assert property (p_timed_expire) // RULE_06
      else $error("timed flag outlived its hold period");

   property p_nd_gap;
      $rose(st_r.flags[E_DATA]) |-> $past(st_r.nd_gap) == 32'h0;
   endproperty
   a_nd_gap: assert property (p_nd_gap) // RULE_15
      else $error("new-sample flag rose inside its low gap");

   property p_nd_clear;
      (ce && acq_start && !acc_wr && st_r.flags[E_DATA]) |=>
         (!st_r.flags[E_DATA] && st_r.nd_gap == ND_GAP_CYC);
   endproperty
   a_nd_clear: assert property (p_nd_clear) // RULE_16
      else $error("new-sample flag not cleared at acquisition start");

   property p_slope_count;
      $rose(st_r.slope_cond) |-> $past(st_r.above_cnt) + 3'h1 >=
         $past(need_n);
   endproperty
   a_slope_count: assert property (p_slope_count) // RULE_19
      else $error("slope asserted before N points above threshold");

   c_latch_clear: cover property (latch_clr && mode == MD_LATCH &&
      st_r.flags != 8'h00);
   c_timed_expire: cover property (mode == MD_TIMED &&
      $fell(st_r.flags[E_LOW]));
   c_slope_assert: cover property ($rose(st_r.slope_cond));
   c_nd_cycle: cover property ($rose(st_r.flags[E_DATA]) ##[1:20]
      $fell(st_r.flags[E_DATA]));

endmodule : aic_interrupt_ctrl

`default_nettype wire

// *** src/aic_pkg.sv ***
// Package with register map, field positions, timing and types of the interrupt core
package aic_pkg;

   // Engine slots, also the bit order of routing and flag vectors
   localparam int ENG_N = 8;
   localparam int E_DATA = 0;
   localparam int E_LOW = 1;
   localparam int E_HIGH = 2;
   localparam int E_SLOPE = 3;
   localparam int E_NOMOT = 4;
   localparam int E_TAP = 5;
   localparam int E_ORIENT = 6;
   localparam int E_FLAT = 7;

   // Register indices; byte address is four times the index
   localparam logic [7:0] REG_FLAGS_A_IDX = 8'h09;
   localparam logic [7:0] REG_FLAGS_B_IDX = 8'h0A;
   localparam logic [7:0] REG_EN_A_IDX = 8'h16;
   localparam logic [7:0] REG_EN_B_IDX = 8'h17;
   localparam logic [7:0] REG_ROUTE_A_IDX = 8'h19;
   localparam logic [7:0] REG_ROUTE_B_IDX = 8'h1B;
   localparam logic [7:0] REG_SRC_IDX = 8'h1E;
   localparam logic [7:0] REG_OUTCTL_IDX = 8'h20;
   localparam logic [7:0] REG_HOLD_IDX = 8'h21;
   localparam logic [7:0] REG_SLOPE_DUR_IDX = 8'h27;
   localparam logic [7:0] REG_THRESH_IDX = 8'h28;
   localparam logic [7:0] REG_RST = 8'h00;

   // Field positions
   localparam int ND_EN_BIT = 4;
   localparam int NOMOT_EN_BIT = 0;
   localparam int ND_FLAG_BIT = 7;
   localparam int LATCH_CLR_BIT = 7;
   localparam int POL_A_BIT = 0;
   localparam int OD_A_BIT = 1;
   localparam int POL_B_BIT = 2;
   localparam int OD_B_BIT = 3;
   localparam int EN_A_LOW_BIT = 3;
   localparam int EN_A_HIGH_BIT = 4;
   localparam int EN_A_TAP_BIT = 5;
   localparam int EN_A_ORIENT_BIT = 6;
   localparam int EN_A_FLAT_BIT = 7;
   localparam int SRC_DATA_BIT = 0;
   localparam int SRC_TAP_BIT = 1;
   localparam int SRC_NOMOT_BIT = 2;
   localparam int SRC_SLOPE_BIT = 3;
   localparam int SRC_HIGH_BIT = 4;
   localparam int SRC_LOW_BIT = 5;
   localparam int MOTION_THRESHOLD_SHIFT = 4;

   // Hold-mode codes
   localparam logic [3:0] MODE_NL0 = 4'h0;
   localparam logic [3:0] MODE_NL1 = 4'h8;
   localparam logic [3:0] MODE_LAT0 = 4'h7;
   localparam logic [3:0] MODE_LAT1 = 4'hF;

   // Times in microseconds and their cycle counts at 200 MHz
   localparam int CLK_MHZ = 200;
   localparam int HOLD_UNIT_US = 250;
   localparam int ND_GAP_US = 50;
   localparam int AUTO_CLR_US = 12500;
   localparam int HOLD_UNIT_CYC_DEF = HOLD_UNIT_US * CLK_MHZ;
   localparam int ND_GAP_CYC_DEF = ND_GAP_US * CLK_MHZ;
   localparam int AUTO_CLR_CYC_DEF = AUTO_CLR_US * CLK_MHZ;

   typedef enum logic [1:0] {MD_NONLATCH, MD_TIMED, MD_LATCH} aic_mode_t;

   typedef struct packed {
      logic valid;
      logic signed [13:0] x;
      logic signed [13:0] y;
      logic signed [13:0] z;
   } aic_sample_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } aic_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } aic_apb_rsp_t;

   typedef struct packed {
      logic o;
      logic oe;
   } aic_pin_t;

   // Hold period of a timed code, in units of 250 us
   function automatic logic [15:0] hold_units(input logic [3:0] code);
      logic [15:0] u;
      u = 16'h0001;
      unique case (code)
         4'h1: u = 16'd1000;
         4'h2: u = 16'd2000;
         4'h3: u = 16'd4000;
         4'h4: u = 16'd8000;
         4'h5: u = 16'd16000;
         4'h6: u = 16'd32000;
         4'h9: u = 16'd1;
         4'hA: u = 16'd2;
         4'hB: u = 16'd4;
         4'hC: u = 16'd50;
         4'hD: u = 16'd100;
         4'hE: u = 16'd200;
         default: u = 16'h0001;
      endcase
      return u;
   endfunction : hold_units

endpackage : aic_pkg

// *** sim/aic_host_pins.sv ***
// Host-side pin model: resolves both interrupt wires with board pulls
`timescale 1ns/1ps
`default_nettype none
module aic_host_pins (
   input wire aic_pkg::aic_pin_t pin_a,
   input wire aic_pkg::aic_pin_t pin_b,
   input wire logic pull_a,
   input wire logic pull_b,
   output logic wire_a,
   output logic wire_b
);
   import aic_pkg::*;
   // A released open-drain line settles at its resistor level
   assign wire_a = pin_a.oe ? pin_a.o : pull_a;
   assign wire_b = pin_b.oe ? pin_b.o : pull_b;
endmodule : aic_host_pins
`default_nettype wire

// *** sim/accel_interrupt_controller_tb.sv ***
// Bench of the interrupt core: APB driver, flag model, pin checks
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
$display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module accel_interrupt_controller_tb;
   import aic_pkg::*;
   localparam int HU = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic acc_wr = 1'b0;
   logic acq = 1'b0;
   logic [7:0] cf = 8'h00;
   logic [7:0] cu = 8'h00;
   aic_apb_req_t req = '0;
   aic_apb_rsp_t rsp;
   aic_sample_t sf = '0;
   aic_sample_t su = '0;
   aic_pin_t pa;
   aic_pin_t pb;
   logic wa;
   logic wb;
   logic [7:0] mdl [64];
   logic [7:0] fl = 8'h00;
   logic [31:0] rdv;
   logic err;
   int bad_count = 0;
   int checks = 0;
   logic [3:0] cd [9] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD,
      4'hE};
   int un [9] = '{1000, 2000, 4000, 1, 2, 4, 50, 100, 200};
   logic [3:0] lm [4] = '{4'h0, 4'h8, 4'h7, 4'hF};
   int xs [6] = '{0, 100, 200, 232, 232, 232};
   int xe [6] = '{0, 0, 1, 1, 0, 0};

   // 200 MHz clock
   always #2.5 clk = ~clk;

   aic_interrupt_ctrl #(.HOLD_UNIT_CYC(HU), .ND_GAP_CYC(8),
      .AUTO_CLR_CYC(16)) u_aic_interrupt_ctrl (.clk(clk), .rst_n(rst_n),
      .ce(ce), .apb_req(req), .apb_rsp(rsp), .samp_filt(sf),
      .samp_unf(su), .acc_wr(acc_wr), .acq_start(acq),
      .ext_cond_filt(cf), .ext_cond_unf(cu), .irq_pin_a(pa),
      .irq_pin_b(pb));

   // Pulls sit at the inactive level chosen by each polarity bit
   aic_host_pins u_aic_host_pins (.pin_a(pa), .pin_b(pb),
      .pull_a(~mdl[REG_OUTCTL_IDX][0]), .pull_b(~mdl[REG_OUTCTL_IDX][2]),
      .wire_a(wa), .wire_b(wb));

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   task automatic done(input string s);
      $display("test %s done, %0d mismatches", s, bad_count);
   endtask : done

   // One APB transfer; the model mirrors writes the slave accepts
   task automatic apb(input logic w, input logic [7:0] ix,
      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      req <= '{1'b1, 1'b0, w, {2'b00, ix, 2'b00}, {24'h000000, d}};
      @(posedge clk);
      req.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      rdv = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
      if (rsp.pready !== 1'b1) begin
         bad_count++;
         summarize();
      end
      // Status words are read-only; latch clear reads back as 0
      if (w && ix != REG_FLAGS_A_IDX && ix != REG_FLAGS_B_IDX) begin
         mdl[ix] = (ix == REG_HOLD_IDX) ? (d & 8'h0F) : d;
      end
   endtask : apb

   task automatic wr(input logic [7:0] ix, input logic [7:0] d);
      apb(1'b1, ix, d);
   endtask : wr

   task automatic rdc(input logic [7:0] ix, input logic [7:0] e);
      apb(1'b0, ix, 8'h00);
      `CHK(rdv, {24'h000000, e})
   endtask : rdc

   function automatic logic [1:0] pexp(input logic [7:0] rt,
      input logic pol, input logic od);
      logic act;
      act = |(rt & fl);
      return {act ? pol : ~pol, od ? act : 1'b1};
   endfunction : pexp

   // Wire level and enable against the flag model
   task automatic pins();
      logic [7:0] c;
      #1;
      c = mdl[REG_OUTCTL_IDX];
      `CHK({wa, pa.oe}, pexp(mdl[REG_ROUTE_A_IDX], c[0], c[1]))
      `CHK({wb, pb.oe}, pexp(mdl[REG_ROUTE_B_IDX], c[2], c[3]))
   endtask : pins

   task automatic flg();
      rdc(REG_FLAGS_A_IDX, fl & 8'hFE);
      rdc(REG_FLAGS_B_IDX, {fl[0], 7'h00});
      pins();
   endtask : flg

   task automatic cond(input logic [7:0] f, input logic [7:0] u);
      @(posedge clk);
      cf <= f;
      cu <= u;
   endtask : cond

   task automatic acc();
      @(posedge clk);
      acc_wr <= 1'b1;
      @(posedge clk);
      acc_wr <= 1'b0;
   endtask : acc

   // Main sequence
   initial begin
      logic [7:0] r;
      for (int i = 0; i < 64; i++) mdl[i] = 8'h00;
      void'($urandom(30565));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      flg();
      done("reset");
      r = 8'($urandom);
      wr(REG_ROUTE_A_IDX, r);
      wr(REG_ROUTE_B_IDX, ~r);
      rdc(REG_ROUTE_A_IDX, r);
      rdc(REG_ROUTE_B_IDX, ~r);
      wr(REG_FLAGS_A_IDX, 8'hFF);
      rdc(REG_FLAGS_A_IDX, 8'h00);
      rdc(8'h3F, 8'h00);
      `CHK(err, 1'b1)
      wr(REG_ROUTE_A_IDX, 8'h0B);
      wr(REG_ROUTE_B_IDX, 8'h04);
      wr(REG_OUTCTL_IDX, 8'h05);
      wr(REG_EN_A_IDX, 8'h18);
      cond(8'h02, 8'h00);
      pins();
      acc();
      fl = 8'h02;
      flg();
      cond(8'h04, 8'h00);
      acc();
      fl = 8'h04;
      flg();
      wr(REG_SRC_IDX, 8'h10);
      acc();
      fl = 8'h00;
      flg();
      cond(8'h00, 8'h04);
      acc();
      fl = 8'h04;
      flg();
      wr(REG_EN_A_IDX, 8'h08);
      fl = 8'h00;
      flg();
      wr(REG_SRC_IDX, 8'h00);
      cond(8'h02, 8'h00);
      acc();
      fl = 8'h02;
      cond(8'h00, 8'h00);
      // Freeze stretches a read and swallows a sample write
      fork
         rdc(REG_FLAGS_A_IDX, 8'h02);
         begin
            repeat (2) @(posedge clk);
            ce <= 1'b0;
            @(posedge clk);
            acc_wr <= 1'b1;
            @(posedge clk);
            acc_wr <= 1'b0;
            @(posedge clk);
            ce <= 1'b1;
         end
      join
      pins();
      for (int c = 0; c < 16; c++) begin
         wr(REG_OUTCTL_IDX, 8'(c));
         pins();
      end
      done("routing");
      // Non-latched and latched code families: stays, clears, re-arms
      foreach (lm[i]) begin
         wr(REG_HOLD_IDX, {4'h0, lm[i]});
         cond(8'h02, 8'h00);
         acc();
         cond(8'h00, 8'h00);
         acc();
         fl = (lm[i][2:0] == 3'h7) ? 8'h02 : 8'h00;
         flg();
         cond(8'h02, 8'h00);
         wr(REG_HOLD_IDX, {4'h8, lm[i]});
         fl = 8'h00;
         flg();
         acc();
         fl = 8'h02;
         pins();
         cond(8'h00, 8'h00);
         wr(REG_HOLD_IDX, {4'h8, lm[i]});
         acc();
         fl = 8'h00;
         flg();
      end
      done("modes");
      // Codes 4 to 6 are left out: their holds exceed the run budget
      foreach (cd[i]) begin
         wr(REG_HOLD_IDX, {4'h0, cd[i]});
         cond(8'h02, 8'h00);
         acc();
         fl = 8'h02;
         repeat (un[i] * HU + 4) @(posedge clk);
         pins();
         cond(8'h00, 8'h00);
         repeat (2) @(posedge clk);
         fl = 8'h00;
         pins();
         cond(8'h02, 8'h00);
         acc();
         fl = 8'h02;
         cond(8'h00, 8'h00);
         repeat (un[i] * HU - 3) @(posedge clk);
         pins();
         repeat (4) @(posedge clk);
         fl = 8'h00;
         pins();
      end
      done("timed");
      wr(REG_HOLD_IDX, 8'h07);
      wr(REG_EN_A_IDX, 8'h00);
      wr(REG_EN_B_IDX, 8'h10);
      acc();
      fl = 8'h01;
      flg();
      @(posedge clk);
      acq <= 1'b1;
      @(posedge clk);
      acq <= 1'b0;
      fl = 8'h00;
      pins();
      acc();
      pins();
      repeat (10) @(posedge clk);
      acc();
      fl = 8'h01;
      flg();
      wr(REG_EN_B_IDX, 8'h00);
      fl = 8'h00;
      flg();
      done("new sample");
      // Orientation ignores unfiltered data and clears after its fixed time
      wr(REG_HOLD_IDX, 8'h00);
      wr(REG_SRC_IDX, 8'h3F);
      wr(REG_EN_A_IDX, 8'h40);
      cond(8'h00, 8'h40);
      acc();
      rdc(REG_FLAGS_A_IDX, 8'h00);
      cond(8'h40, 8'h00);
      acc();
      cond(8'h00, 8'h00);
      acc();
      fl = 8'h40;
      flg();
      repeat (16) @(posedge clk);
      fl = 8'h00;
      flg();
      wr(REG_SRC_IDX, 8'h00);
      done("auto clear");
      // Threshold 2 is 32 counts, two points needed to change
      wr(REG_THRESH_IDX, 8'h02);
      wr(REG_SLOPE_DUR_IDX, 8'h01);
      wr(REG_EN_A_IDX, 8'h01);
      foreach (xs[i]) begin
         @(posedge clk);
         sf <= {1'b1, 14'(xs[i]), 28'($urandom)};
         su <= 43'({$urandom, $urandom});
         @(posedge clk);
         sf.valid <= 1'b0;
         acc();
         fl = (xe[i] != 0) ? 8'h08 : 8'h00;
         pins();
      end
      done("slope");
      summarize();
   end
endmodule : accel_interrupt_controller_tb
`default_nettype wire
